// ---- fbes_seq.v ----
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "fbes_map.vh"
module fbes_seq #(
	parameter PULSE_CYC = `FBES_PULSE_CYC,
	parameter GAP_CYC   = `FBES_GAP_CYC,
	parameter TW        = 20
) (
	clk,
	rst_b,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	prog_voltage_sense_bit,
	tx_buffer0_empty_flag,
	tx_flag_reg,
	flash_addr,
	flash_wdata,
	flash_wr,
	flash_rd,
	flash_rdata,
	addr_data_latch_bit,
	erase_select_bit,
	pulse_enable_bit,
	busy,
	irq
);
	input  wire        clk;
	input  wire        rst_b;
	input  wire [3:0]  reg_addr;
	input  wire [15:0] reg_wdata;
	input  wire        reg_wr;
	input  wire        reg_rd;
	output reg  [15:0] reg_rdata;
	input  wire        prog_voltage_sense_bit;
	input  wire        tx_buffer0_empty_flag;
	output reg         tx_flag_reg;
	output reg  [15:0] flash_addr;
	output reg  [15:0] flash_wdata;
	output reg         flash_wr;
	output reg         flash_rd;
	input  wire [15:0] flash_rdata;
	output reg         addr_data_latch_bit;
	output reg         erase_select_bit;
	output reg         pulse_enable_bit;
	output reg         busy;
	output reg         irq;

	localparam [3:0] S_IDLE   = 4'h0;
	localparam [3:0] S_VCHK   = 4'h1;
	localparam [3:0] S_LATCH  = 4'h2;
	localparam [3:0] S_PON    = 4'h3;
	localparam [3:0] S_PWAIT  = 4'h4;
	localparam [3:0] S_GAP    = 4'h5;
	localparam [3:0] S_GWAIT  = 4'h6;
	localparam [3:0] S_COUNT  = 4'h7;
	localparam [3:0] S_VRD    = 4'h8;
	localparam [3:0] S_VCMP   = 4'h9;
	localparam [3:0] S_DECIDE = 4'hA;
	localparam [3:0] S_FINISH = 4'hB;
	localparam [3:0] S_TXWAIT = 4'hC;

	localparam [TW-1:0] PULSE_D = PULSE_CYC[TW-1:0];
	localparam [TW-1:0] GAP_D   = GAP_CYC[TW-1:0];

	reg [3:0]  state_r;
	reg [15:0] start_addr_r;
	reg [15:0] word_count_r;
	reg [15:0] erase_pulse_limit_r;
	reg [7:0]  status_code_byte_r;
	reg [15:0] pulse_counter_r;
	reg        margin_phase_flag_r;
	reg        verify_ok_r;
	reg [15:0] words_left_r;
	reg [`FBES_IRQ_W-1:0] irq_stat_r;
	reg [`FBES_IRQ_W-1:0] irq_mask_r;
	reg        tmr_load_r;
	reg [TW-1:0] tmr_delay_r;

	wire       vsense_s;
	wire       tmr_flag;
	wire       wr_ctrl;
	wire       start_req;
	reg  [`FBES_IRQ_W-1:0] irq_ev;
	reg  [`FBES_IRQ_W-1:0] irq_stat_nxt;
	reg  [15:0] rdata_nxt;

	// Voltage sense comes from a pin, so it is synchronised first
	fbes_sync u_vsync (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (prog_voltage_sense_bit),
		.dout  (vsense_s)
	);

	fbes_timer #(
		.TW (TW)
	) u_tmr (
		.clk   (clk),
		.rst_b (rst_b),
		.load  (tmr_load_r),
		.delay (tmr_delay_r),
		.flag  (tmr_flag)
	);

	assign wr_ctrl   = reg_wr && reg_addr == `FBES_ADDR_CTRL;
	assign start_req = wr_ctrl && reg_wdata[`FBES_CTRL_START_BIT];

	// Register writes; command parameters are locked while a sequence runs
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			start_addr_r        <= `FBES_START_RST;
			word_count_r        <= `FBES_COUNT_RST;
			erase_pulse_limit_r <= `FBES_LIMIT_RST;
			irq_mask_r          <= `FBES_MASK_RST;
		end else if (reg_wr && !busy) begin
			case (reg_addr)
			`FBES_ADDR_START: begin
				start_addr_r <= reg_wdata;
			end
			`FBES_ADDR_COUNT: begin
				word_count_r <= reg_wdata;
			end
			`FBES_ADDR_LIMIT: begin
				erase_pulse_limit_r <= reg_wdata;
			end
			`FBES_ADDR_IRQ_MASK: begin
				irq_mask_r <= reg_wdata[`FBES_IRQ_W-1:0];
			end
			default: begin
			end
			endcase
		end else if (reg_wr && reg_addr == `FBES_ADDR_IRQ_MASK) begin
			irq_mask_r <= reg_wdata[`FBES_IRQ_W-1:0];
		end
	end

	// Sticky events; an event in the clearing cycle survives the clear
	always @* begin
		irq_stat_nxt = irq_stat_r;
		if (reg_wr && reg_addr == `FBES_ADDR_IRQ_STAT) begin
			irq_stat_nxt = irq_stat_r & ~reg_wdata[`FBES_IRQ_W-1:0];
		end
		irq_stat_nxt = irq_stat_nxt | irq_ev;
	end

	always @* begin
		case (reg_addr)
		`FBES_ADDR_CTRL:     rdata_nxt = {15'h0000, busy};
		`FBES_ADDR_START:    rdata_nxt = start_addr_r;
		`FBES_ADDR_COUNT:    rdata_nxt = word_count_r;
		`FBES_ADDR_STATUS:   rdata_nxt = {8'h00, status_code_byte_r};
		`FBES_ADDR_LIMIT:    rdata_nxt = erase_pulse_limit_r;
		`FBES_ADDR_IRQ_STAT: rdata_nxt = {14'h0000, irq_stat_r};
		`FBES_ADDR_IRQ_MASK: rdata_nxt = {14'h0000, irq_mask_r};
		`FBES_ADDR_PULSES:   rdata_nxt = pulse_counter_r;
		default:             rdata_nxt = 16'h0000;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata  <= 16'h0000;
			irq_stat_r <= {`FBES_IRQ_W{1'b0}};
			irq        <= 1'b0;
		end else begin
			reg_rdata  <= reg_rd ? rdata_nxt : 16'h0000;
			irq_stat_r <= irq_stat_nxt;
			irq        <= |(irq_stat_nxt & irq_mask_r);
		end
	end

	// Erase sequencer
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r             <= S_IDLE;
			status_code_byte_r  <= `FBES_STATUS_NONE;
			pulse_counter_r     <= 16'h0000;
			margin_phase_flag_r <= 1'b0;
			verify_ok_r         <= 1'b0;
			words_left_r        <= 16'h0000;
			tmr_load_r          <= 1'b0;
			tmr_delay_r         <= {TW{1'b0}};
			flash_addr          <= 16'h0000;
			flash_wdata         <= 16'h0000;
			flash_wr            <= 1'b0;
			flash_rd            <= 1'b0;
			addr_data_latch_bit <= 1'b0;
			erase_select_bit    <= 1'b0;
			pulse_enable_bit    <= 1'b0;
			tx_flag_reg         <= 1'b0;
			busy                <= 1'b0;
			irq_ev              <= {`FBES_IRQ_W{1'b0}};
		end else begin
			tmr_load_r  <= 1'b0;
			flash_wr    <= 1'b0;
			flash_rd    <= 1'b0;
			tx_flag_reg <= 1'b0;
			irq_ev      <= {`FBES_IRQ_W{1'b0}};
			case (state_r)
			S_IDLE: begin
				if (start_req) begin
					busy                <= 1'b1;
					status_code_byte_r  <= `FBES_STATUS_NONE;
					pulse_counter_r     <= 16'h0000;
					margin_phase_flag_r <= 1'b0;
					state_r             <= S_VCHK;
				end
			end
			S_VCHK: begin
				if (vsense_s) begin
					status_code_byte_r <= `FBES_STATUS_VOLT;
					state_r            <= S_LATCH;
				end else begin
					irq_ev[`FBES_IRQ_NOVOLT_BIT] <= 1'b1;
					state_r                      <= S_FINISH;
				end
			end
			S_LATCH: begin
				addr_data_latch_bit <= 1'b1;
				erase_select_bit    <= 1'b1;
				flash_addr          <= start_addr_r;
				flash_wdata         <= `FBES_ERASED_WORD;
				flash_wr            <= 1'b1;
				state_r             <= S_PON;
			end
			S_PON: begin
				pulse_enable_bit <= 1'b1;
				tmr_delay_r      <= PULSE_D;
				tmr_load_r       <= 1'b1;
				state_r          <= S_PWAIT;
			end
			S_PWAIT: begin
				// The load takes a cycle to clear the old flag, so skip the first look
				if (tmr_flag && !tmr_load_r) begin
					pulse_enable_bit <= 1'b0;
					state_r          <= S_GAP;
				end
			end
			S_GAP: begin
				tmr_delay_r <= GAP_D;
				tmr_load_r  <= 1'b1;
				state_r     <= S_GWAIT;
			end
			S_GWAIT: begin
				if (tmr_flag && !tmr_load_r) begin
					state_r <= S_COUNT;
				end
			end
			S_COUNT: begin
				if (margin_phase_flag_r) begin
					pulse_counter_r <= pulse_counter_r - 16'h0001;
					if (pulse_counter_r == 16'h0001) begin
						state_r <= S_VRD;
					end else begin
						state_r <= S_LATCH;
					end
				end else begin
					pulse_counter_r <= pulse_counter_r + 16'h0001;
					state_r         <= S_VRD;
				end
				flash_addr   <= start_addr_r;
				words_left_r <= word_count_r;
				verify_ok_r  <= 1'b1;
			end
			S_VRD: begin
				if (words_left_r == 16'h0000) begin
					state_r <= S_DECIDE;
				end else begin
					flash_rd <= 1'b1;
					state_r  <= S_VCMP;
				end
			end
			S_VCMP: begin
				// Read data from the array stands in the strobe cycle itself and is sampled at its closing edge
				if (flash_rdata != `FBES_ERASED_WORD) begin
					verify_ok_r <= 1'b0;
					state_r     <= S_DECIDE;
				end else begin
					flash_addr   <= flash_addr + `FBES_WORD_STEP;
					words_left_r <= words_left_r - 16'h0001;
					state_r      <= S_VRD;
				end
			end
			S_DECIDE: begin
				if (verify_ok_r) begin
					if (pulse_counter_r == 16'h0000) begin
						status_code_byte_r <= `FBES_STATUS_OK;
						state_r            <= S_FINISH;
					end else begin
						margin_phase_flag_r <= 1'b1;
						state_r             <= S_LATCH;
					end
				end else if (pulse_counter_r == 16'h0000) begin
					state_r <= S_FINISH;
				end else if (pulse_counter_r == erase_pulse_limit_r) begin
					state_r <= S_FINISH;
				end else begin
					state_r <= S_LATCH;
				end
			end
			S_FINISH: begin
				addr_data_latch_bit <= 1'b0;
				erase_select_bit    <= 1'b0;
				pulse_enable_bit    <= 1'b0;
				state_r             <= S_TXWAIT;
			end
			S_TXWAIT: begin
				if (tx_buffer0_empty_flag) begin
					tx_flag_reg                <= 1'b1;
					irq_ev[`FBES_IRQ_DONE_BIT] <= 1'b1;
					busy                       <= 1'b0;
					state_r                    <= S_IDLE;
				end
			end
			default: begin
				state_r <= S_IDLE;
			end
			endcase
		end
	end
endmodule

// ---- fbes_map.vh ----
`ifndef FBES_MAP_VH
`define FBES_MAP_VH

// Register word offsets on the plain register port
`define FBES_ADDR_CTRL       4'h0
`define FBES_ADDR_START      4'h1
`define FBES_ADDR_COUNT      4'h2
`define FBES_ADDR_STATUS     4'h3
`define FBES_ADDR_LIMIT      4'h4
`define FBES_ADDR_IRQ_STAT   4'h5
`define FBES_ADDR_IRQ_MASK   4'h6
`define FBES_ADDR_PULSES     4'h7

// Field positions
`define FBES_CTRL_START_BIT  0
`define FBES_CTRL_BUSY_BIT   0
`define FBES_IRQ_DONE_BIT    0
`define FBES_IRQ_NOVOLT_BIT  1
`define FBES_IRQ_W           2

// Reset values
`define FBES_START_RST       16'h0000
`define FBES_COUNT_RST       16'h0000
`define FBES_LIMIT_RST       16'h0020
`define FBES_MASK_RST        2'h0

// Status code values
`define FBES_STATUS_NONE     8'h00
`define FBES_STATUS_VOLT     8'h01
`define FBES_STATUS_OK       8'h02

// Array constants
`define FBES_ERASED_WORD     16'hFFFF
`define FBES_WORD_STEP       16'h0002

// Timing
`define FBES_CLK_HZ          50000000
`define FBES_PULSE_MS        10
`define FBES_GAP_MS          1
`define FBES_PULSE_CYC       ((`FBES_PULSE_MS * `FBES_CLK_HZ) / 1000)
`define FBES_GAP_CYC         ((`FBES_GAP_MS * `FBES_CLK_HZ) / 1000)

`endif

// ---- fbes_sync.v ----
`timescale 1ns/1ns
module fbes_sync (
	clk,
	rst_b,
	din,
	dout
);
	input  wire clk;
	input  wire rst_b;
	input  wire din;
	output wire dout;

	reg meta_r;
	reg sync_r;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= din;
			sync_r <= meta_r;
		end
	end

	assign dout = sync_r;
endmodule

// ---- fbes_timer.v ----
`timescale 1ns/1ns
module fbes_timer #(
	parameter TW = 20
) (
	clk,
	rst_b,
	load,
	delay,
	flag
);
	input  wire          clk;
	input  wire          rst_b;
	input  wire          load;
	input  wire [TW-1:0] delay;
	output wire          flag;

	reg [TW-1:0] cnt_r;
	reg [TW-1:0] cmp_r;
	reg          armed_r;
	reg          flag_r;

	// Free-running count; compare is set relative to it so the delay wraps cleanly
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r   <= {TW{1'b0}};
			cmp_r   <= {TW{1'b0}};
			armed_r <= 1'b0;
			flag_r  <= 1'b0;
		end else begin
			cnt_r <= cnt_r + {{(TW-1){1'b0}}, 1'b1};
			if (load) begin
				cmp_r   <= cnt_r + delay;
				armed_r <= 1'b1;
				flag_r  <= 1'b0;
			end else if (armed_r && cnt_r == cmp_r) begin
				armed_r <= 1'b0;
				flag_r  <= 1'b1;
			end
		end
	end

	assign flag = flag_r;
endmodule

// ---- fbes_seq_assertions.sv ----
`timescale 1ns/1ns
module fbes_seq_assertions #(
	parameter PULSE_CYC = 500000,
	parameter GAP_CYC   = 50000
) (
	input wire clk,
	input wire rst_b,
	input wire tx_buffer0_empty_flag,
	input wire tx_flag_reg,
	input wire flash_wr,
	input wire flash_rd,
	input wire addr_data_latch_bit,
	input wire erase_select_bit,
	input wire pulse_enable_bit,
	input wire busy
);
	reg [31:0] hi_cnt_r;
	reg [31:0] lo_cnt_r;
	// Low count starts large so the first latching write of a run is never judged
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hi_cnt_r <= 32'h0000_0000;
			lo_cnt_r <= 32'h00FF_FFFF;
		end else begin
			hi_cnt_r <= pulse_enable_bit ? hi_cnt_r + 32'h0000_0001 : 32'h0000_0000;
			lo_cnt_r <= pulse_enable_bit ? 32'h0000_0000 : lo_cnt_r + 32'h0000_0001;
		end
	end
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_b);
	latch_before_write_a: assert property (flash_wr |-> addr_data_latch_bit && erase_select_bit)
		else $error("latching write without latch and erase select");
	write_then_pulse_a: assert property (flash_wr |=> pulse_enable_bit && erase_select_bit)
		else $error("pulse enable did not follow latching write");
	pulse_width_a: assert property ($fell(pulse_enable_bit) |-> hi_cnt_r >= PULSE_CYC && hi_cnt_r <= PULSE_CYC + 4)
		else $error("erase pulse length out of range");
	gap_before_next_a: assert property (flash_wr || flash_rd |-> lo_cnt_r >= GAP_CYC)
		else $error("recovery gap after pulse too short");
	read_volt_off_a: assert property (flash_rd |-> !pulse_enable_bit ##1 !pulse_enable_bit)
		else $error("verify read with voltage applied");
	finish_clears_ctrl_a: assert property (tx_flag_reg |-> !addr_data_latch_bit && !erase_select_bit && !pulse_enable_bit)
		else $error("control bits not cleared at finish");
	tx_waits_empty_a: assert property (tx_flag_reg |-> $past(tx_buffer0_empty_flag) && $past(busy))
		else $error("launch without empty transmit buffer");
	busy_ends_tx_a: assert property ($fell(busy) |-> tx_flag_reg)
		else $error("run ended without launch");
endmodule
bind fbes_seq fbes_seq_assertions #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) fbes_seq_assertions_inst (
	.clk(clk), .rst_b(rst_b), .tx_buffer0_empty_flag(tx_buffer0_empty_flag), .tx_flag_reg(tx_flag_reg),
	.flash_wr(flash_wr), .flash_rd(flash_rd), .addr_data_latch_bit(addr_data_latch_bit),
	.erase_select_bit(erase_select_bit), .pulse_enable_bit(pulse_enable_bit), .busy(busy));

// ---- fbes_flash_model.sv ----
`timescale 1ns/1ns
module fbes_flash_model (
	input  wire        clk,
	input  wire        rst_b,
	input  wire [15:0] flash_addr,
	input  wire        flash_rd,
	input  wire        pulse_enable_bit,
	input  wire        erase_select_bit,
	input  wire [7:0]  need,
	output wire [15:0] flash_rdata
);
	reg [7:0]  done_r;
	reg        pe_d_r;
	reg [15:0] junk_r;
	// The sequencer samples at the edge that ends its strobe cycle, so data stands in that cycle
	// Outside the strobe the bus toggles so that stale use shows
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			done_r <= 8'h00;
			pe_d_r <= 1'b0;
			junk_r <= 16'h5A5A;
		end else begin
			pe_d_r <= pulse_enable_bit;
			if (pe_d_r && !pulse_enable_bit && erase_select_bit && done_r != 8'hFF)
				done_r <= done_r + 8'h01;
			junk_r <= ~junk_r;
		end
	end
	assign flash_rdata = flash_rd ? ((done_r >= need) ? 16'hFFFF : (flash_addr & 16'h7FFF)) : junk_r;
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
`include "fbes_map.vh"
module tb;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [3:0]  reg_addr = 4'h0;
	reg  [15:0] reg_wdata = 16'h0000;
	reg         reg_wr = 1'b0;
	reg         reg_rd = 1'b0;
	reg         sense = 1'b0;
	reg         tx_empty = 1'b1;
	reg  [7:0]  need = 8'h03;
	wire [15:0] reg_rdata, flash_addr, flash_wdata, flash_rdata;
	wire        tx_flag_reg, flash_wr, flash_rd, latch, erase_sel, pe, busy, irq;
	integer     mismatches = 0, n_tests = 0, cyc = 0, n_pulse, n_rd, n_tx, n_bad;
	reg  [15:0] st, cnt, v;
	reg         pe_d = 1'b0;
	fbes_seq #(.PULSE_CYC(20), .GAP_CYC(5)) fbes_seq_inst (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.prog_voltage_sense_bit(sense), .tx_buffer0_empty_flag(tx_empty), .tx_flag_reg(tx_flag_reg),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_rd(flash_rd),
		.flash_rdata(flash_rdata), .addr_data_latch_bit(latch), .erase_select_bit(erase_sel),
		.pulse_enable_bit(pe), .busy(busy), .irq(irq));
	fbes_flash_model fbes_flash_model_inst (.clk(clk), .rst_b(rst_b), .flash_addr(flash_addr), .flash_rd(flash_rd),
		.pulse_enable_bit(pe), .erase_select_bit(erase_sel), .need(need), .flash_rdata(flash_rdata));
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc = cyc + 1;
		pe_d <= pe;
		if (pe && !pe_d) n_pulse = n_pulse + 1;
		if (tx_flag_reg) n_tx = n_tx + 1;
		if (flash_rd) n_rd = n_rd + 1;
		if ((flash_rd || flash_wr) && (flash_addr < st || flash_addr >= st + 2 * cnt)) n_bad = n_bad + 1;
		if (flash_wr && flash_wdata !== `FBES_ERASED_WORD) n_bad = n_bad + 1;
		if (cyc == 20000) begin
			mismatches = mismatches + 1;
			report_and_stop;
		end
	end
	task report_and_stop;
		begin
			if (mismatches == 0 && n_tests > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		begin
			@(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
			@(posedge clk) reg_wr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
			@(posedge clk) reg_rd <= 1'b0;
			#1 v = reg_rdata;
		end
	endtask
	task do_reset(input s, input [7:0] nd);
		begin
			@(posedge clk) begin rst_b <= 1'b0; sense <= s; need <= nd; tx_empty <= 1'b1; end
			repeat (5) @(posedge clk);
			rst_b <= 1'b1;
			@(posedge clk) #1;
			n_pulse = 0; n_rd = 0; n_tx = 0; n_bad = 0;
		end
	endtask
	task start_run(input [15:0] s, input [15:0] c);
		begin
			st = s; cnt = c;
			wr(`FBES_ADDR_START, s);
			wr(`FBES_ADDR_COUNT, c);
			wr(`FBES_ADDR_CTRL, 16'h0001);
			cmp({15'h0000, busy}, 16'h0001);
		end
	endtask
	task t_regs;
		begin
			rd(`FBES_ADDR_LIMIT); cmp(v, `FBES_LIMIT_RST);
			rd(`FBES_ADDR_IRQ_MASK); cmp(v, 16'h0000);
			rd(`FBES_ADDR_COUNT); cmp(v, `FBES_COUNT_RST);
			rd(4'hF); cmp(v, 16'h0000);
			wr(`FBES_ADDR_STATUS, 16'h00FF);
			rd(`FBES_ADDR_STATUS); cmp(v, 16'h0000);
		end
	endtask
	task t_novolt;
		begin
			@(posedge clk) sense <= 1'b0;
			repeat (3) @(posedge clk);
			#1 n_pulse = 0;
			wr(`FBES_ADDR_IRQ_STAT, 16'h0003);
			wr(`FBES_ADDR_IRQ_MASK, 16'h0003);
			start_run(16'h1000, 16'h0004);
			while (busy !== 1'b0) @(posedge clk);
			#1 cmp(n_pulse, 0);
			rd(`FBES_ADDR_STATUS); cmp(v, {8'h00, `FBES_STATUS_NONE});
			rd(`FBES_ADDR_IRQ_STAT); cmp(v & 16'h0002, 16'h0002);
			cmp({15'h0000, irq}, 16'h0001);
			wr(`FBES_ADDR_IRQ_STAT, 16'h0003);
			repeat (3) @(posedge clk);
			#1 cmp({15'h0000, irq}, 16'h0000);
		end
	endtask
	task t_margin;
		begin
			do_reset(1'b1, 8'h03);
			@(posedge clk) tx_empty <= 1'b0;
			start_run(16'h1000, 16'h0004);
			while (latch !== 1'b1) @(posedge clk);
			while (latch !== 1'b0) @(posedge clk);
			repeat (20) @(posedge clk);
			#1 cmp(n_tx, 0);
			cmp({15'h0000, busy}, 16'h0001);
			@(posedge clk) tx_empty <= 1'b1;
			while (busy !== 1'b0) @(posedge clk);
			#1 cmp(n_tx, 1);
			cmp(n_pulse, 6);
			cmp(n_rd, 10);
			cmp(n_bad, 0);
			rd(`FBES_ADDR_STATUS); cmp(v, {8'h00, `FBES_STATUS_OK});
			rd(`FBES_ADDR_PULSES); cmp(v, 16'h0000);
			cmp({15'h0000, irq}, 16'h0000);
			wr(`FBES_ADDR_IRQ_MASK, 16'h0001);
			repeat (3) @(posedge clk);
			#1 cmp({15'h0000, irq}, 16'h0001);
		end
	endtask
	task t_limit;
		begin
			do_reset(1'b1, 8'h0A);
			wr(`FBES_ADDR_LIMIT, 16'h0002);
			start_run(16'h2000, 16'h0003);
			while (busy !== 1'b0) @(posedge clk);
			#1 cmp(n_pulse, 2);
			cmp(n_rd, 2);
			rd(`FBES_ADDR_STATUS); cmp(v, {8'h00, `FBES_STATUS_VOLT});
			rd(`FBES_ADDR_PULSES); cmp(v, 16'h0002);
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk) #1;
		t_regs;
		t_margin;
		t_limit;
		t_novolt;
		report_and_stop;
	end
endmodule
